// *** verilog/bfr_top.v ***
/*
  Fault response selection for low-voltage-bus over/undervoltage faults and
  for excessive phase removal, with the response registers, status byte and
  fault flag pin.
  Assumes a simple byte register port driven by the management-bus engine on
  clock_in, and asynchronous comparator and enable pin levels.
*/
`timescale 1ns/1ps
`include "bfr_map.vh"

// Functional notes
// RULE1 - With the phase-removal fault enable clear, disabling phases never causes a fault.
// RULE2 - With it set and over half the configured phases disabled, the phase response field acts.
// RULE3 - Response fields apply only when the global individual-response bit is set, else the mode pin decides.
// RULE4 - Bits 1:0 select the output overvoltage response: 00 flag, 01 hiccup, 10 latch, 11 flag.
// RULE5 - Bits 3:2 select the output undervoltage response with the same encoding.
// RULE6 - Bits 5:4 select the input overvoltage response with the same encoding.
// RULE7 - Output OV, output UV and input OV set status bits 0, 1 and 2.
// RULE8 - Any detected fault drives the active-low fault flag low.
// RULE9 - Flag-only records and flags the fault while switching carries on.
// RULE10 - Hiccup stops switching and restarts after the fault stays removed for 500 ms.
// RULE11 - Latch-off keeps switching stopped until an enable pin is toggled.
// RULE12 - The bus response register is a byte, read-write, write-protectable, resetting to zero.
// RULE13 - Bits 7:6 select the input undervoltage response and that fault sets status bit 3.
// RULE14 - The phase response field in bits 7:6 uses the same four-code encoding.
// RULE15 - Fault inputs are synchronised levels and the hiccup delay restarts when the fault returns.
// RULE16 - Latch-off clears only on a low-then-high toggle of an enable, and a live fault relatches.
module bfr_top #(
  parameter HICCUP_CYCLES = (`BFR_HICCUP_MS * `BFR_CLK_KHZ),
  parameter NUM_PHASES    = 6
) (
  input  wire       clock_in,
  input  wire       rst_n_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire       write_protect_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_ack_out,
  input  wire       out_ov_in,
  input  wire       out_uv_in,
  input  wire       in_ov_in,
  input  wire       in_uv_in,
  input  wire [1:0] mode_resp_in,
  input  wire       pwm_en_in,
  input  wire       master_en_in,
  output reg        fault_flag_n_out,
  output reg        pwm_stop_out,
  output reg  [3:0] status_out
);
  localparam CW = 30;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [3:0] flt_sync;
  wire [1:0] en_sync;
  wire [1:0] mode_sync;

  bfr_sync2 #(.WIDTH(8)) u_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in ({mode_resp_in, master_en_in, pwm_en_in, in_uv_in, in_ov_in, out_uv_in, out_ov_in}),
    .sync_out ({mode_sync, en_sync, flt_sync})          // [RULE15]
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] phase_ctrl_reg;
  reg [7:0] bus_resp_reg;
  reg [7:0] global_ctrl_reg;
  reg [7:0] phase_dis_reg;
  reg [3:0] status_reg;
  reg [1:0] en_prev_reg;
  reg [1:0] en_low_seen_reg;

  wire wr_ok = reg_wr_in && !write_protect_in;        // [RULE12]
  wire status_clr = reg_wr_in && reg_addr_in == `BFR_OFS_BUS_STATUS;

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      phase_ctrl_reg  <= `BFR_RST_BYTE;
      bus_resp_reg    <= `BFR_RST_BYTE;                 // [RULE12]
      global_ctrl_reg <= `BFR_RST_BYTE;
      phase_dis_reg   <= `BFR_RST_BYTE;
    end else if (wr_ok) begin
      if (reg_addr_in == `BFR_OFS_PHASE_CTRL)
        phase_ctrl_reg <= reg_wdata_in;
      else if (reg_addr_in == `BFR_OFS_BUS_RESP)
        bus_resp_reg <= reg_wdata_in;                   // [RULE12]
      else if (reg_addr_in == `BFR_OFS_GLOBAL_CTRL)
        global_ctrl_reg <= reg_wdata_in;
      else if (reg_addr_in == `BFR_OFS_PHASE_DIS)
        phase_dis_reg <= reg_wdata_in;
    end
  end

  // Status is sticky; a write of ones clears, but a fault present that cycle wins
  wire [3:0] status_next = (status_reg & ~(status_clr ? reg_wdata_in[3:0] : 4'h0)) | flt_sync;

  always @(posedge clock_in) begin
    if (!rst_n_in)
      status_reg <= 4'h0;
    else
      status_reg <= status_next;                        // [RULE7] [RULE13]
  end

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_ack_out   <= 1'b0;
    end else begin
      reg_ack_out <= reg_rd_in || reg_wr_in;
      if (reg_addr_in == `BFR_OFS_PHASE_CTRL)
        reg_rdata_out <= phase_ctrl_reg;
      else if (reg_addr_in == `BFR_OFS_BUS_RESP)
        reg_rdata_out <= bus_resp_reg;
      else if (reg_addr_in == `BFR_OFS_GLOBAL_CTRL)
        reg_rdata_out <= global_ctrl_reg;
      else if (reg_addr_in == `BFR_OFS_PHASE_DIS)
        reg_rdata_out <= phase_dis_reg;
      else if (reg_addr_in == `BFR_OFS_BUS_STATUS)
        reg_rdata_out <= {4'h0, status_reg};
      else
        reg_rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------
  // Response selection
  // ----------------------------------------
  wire indiv_en = global_ctrl_reg[`BFR_INDIV_EN_BIT];

  // Mode pin overrides the field when individual response is off
  function [1:0] pick;
    input [1:0] field;
    input       en;
    input [1:0] mode;
    begin
      pick = en ? field : mode;                         // [RULE3]
    end
  endfunction

  wire [1:0] resp_out_ov = pick(bus_resp_reg[`BFR_OUT_OV_LSB+1:`BFR_OUT_OV_LSB], indiv_en, mode_sync); // [RULE4]
  wire [1:0] resp_out_uv = pick(bus_resp_reg[`BFR_OUT_UV_LSB+1:`BFR_OUT_UV_LSB], indiv_en, mode_sync); // [RULE5]
  wire [1:0] resp_in_ov  = pick(bus_resp_reg[`BFR_IN_OV_LSB+1:`BFR_IN_OV_LSB], indiv_en, mode_sync);   // [RULE6]
  wire [1:0] resp_in_uv  = pick(bus_resp_reg[`BFR_IN_UV_LSB+1:`BFR_IN_UV_LSB], indiv_en, mode_sync);   // [RULE13]
  wire [1:0] resp_phase  = pick(phase_ctrl_reg[`BFR_PHASE_RESP_LSB+1:`BFR_PHASE_RESP_LSB],
                                indiv_en, mode_sync);                                                   // [RULE14]

  // ----------------------------------------
  // Phase removal fault
  // ----------------------------------------
  reg [3:0] dis_count;
  integer   i;
  always @* begin
    dis_count = 4'h0;
    for (i = 0; i < NUM_PHASES; i = i + 1)
      dis_count = dis_count + {3'h0, phase_dis_reg[i + 1]};
  end

  // Strictly more than half of the configured phases
  wire phase_fault = phase_ctrl_reg[`BFR_PHASE_FLT_EN_BIT] &&         // [RULE1]
                     ({dis_count, 1'b0} > NUM_PHASES[4:0]);            // [RULE2]

  // ----------------------------------------
  // Enable toggle detection
  // ----------------------------------------
  // A rearm needs the pin seen low and then high again
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      en_prev_reg     <= 2'h0;
      en_low_seen_reg <= 2'h0;
    end else begin
      en_prev_reg     <= en_sync;
      en_low_seen_reg <= (en_low_seen_reg | ~en_sync) & ~(en_sync & ~en_prev_reg);
    end
  end

  wire rearm = |(en_sync & ~en_prev_reg & en_low_seen_reg);           // [RULE16]

  // ----------------------------------------
  // Fault channels
  // ----------------------------------------
  wire [4:0] chan_fault = {phase_fault, flt_sync};
  wire [9:0] chan_resp  = {resp_phase, resp_in_uv, resp_in_ov, resp_out_uv, resp_out_ov};
  wire [4:0] chan_stop;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_chan
      bfr_fault_chan #(
        .HICCUP_CYCLES (HICCUP_CYCLES),
        .CW            (CW)
      ) u_chan (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .fault_in (chan_fault[g]),
        .resp_in  (chan_resp[2*g+1:2*g]),
        .rearm_in (rearm),
        .stop_out (chan_stop[g])                        // [RULE9] [RULE10] [RULE11]
      );
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      fault_flag_n_out <= 1'b1;
      pwm_stop_out     <= 1'b0;
      status_out       <= 4'h0;
    end else begin
      fault_flag_n_out <= ~(|chan_fault);               // [RULE8]
      pwm_stop_out     <= |chan_stop;
      status_out       <= status_next;
    end
  end
endmodule

// *** verilog/bfr_map.vh ***
/*
  Register offsets, field positions, reset values and timing counts for the
  low-voltage-bus fault response block.
  Assumes it is included by bare name from design files under verilog/.
*/
`ifndef BFR_MAP_VH
`define BFR_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BFR_OFS_PHASE_CTRL   8'hb6
`define BFR_OFS_BUS_RESP     8'hb7
`define BFR_OFS_GLOBAL_CTRL  8'hb0
`define BFR_OFS_PHASE_DIS    8'hbc
`define BFR_OFS_BUS_STATUS   8'hd7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BFR_PHASE_FLT_EN_BIT 5
`define BFR_PHASE_RESP_LSB   6
`define BFR_OUT_OV_LSB       0
`define BFR_OUT_UV_LSB       2
`define BFR_IN_OV_LSB        4
`define BFR_IN_UV_LSB        6
`define BFR_INDIV_EN_BIT     7

// ----------------------------------------
// Reset values and response codes
// ----------------------------------------
`define BFR_RST_BYTE         8'h00
`define BFR_RESP_FLAG        2'h0
`define BFR_RESP_HICCUP      2'h1
`define BFR_RESP_LATCH       2'h2
`define BFR_RESP_FLAG_ALT    2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define BFR_HICCUP_MS        500
`define BFR_CLK_KHZ          125000

`endif

// *** verilog/bfr_sync2.v ***
/*
  Two-flop synchroniser for a bus of asynchronous levels.
  Assumes inputs come from outside the clock domain.
*/
`timescale 1ns/1ps
module bfr_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             clock_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// *** verilog/bfr_fault_chan.v ***
/*
  One fault channel: applies flag-only, hiccup or latch-off to a fault level
  and reports whether PWM switching must be held off.
  Assumes fault_in and the enable inputs are already synchronised.
*/
`timescale 1ns/1ps
`include "bfr_map.vh"
module bfr_fault_chan #(
  parameter HICCUP_CYCLES = 62500000,
  parameter CW            = 27
) (
  input  wire       clock_in,
  input  wire       rst_n_in,
  input  wire       fault_in,
  input  wire [1:0] resp_in,
  input  wire       rearm_in,
  output wire       stop_out
);
  // ----------------------------------------
  // State machine
  // ----------------------------------------
  localparam ST_RUN    = 3'b001;
  localparam ST_HICCUP = 3'b010;
  localparam ST_LATCH  = 3'b100;

  reg [2:0]    state_reg;
  reg [2:0]    state_next;
  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] cnt_next;

  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_RUN: begin
        cnt_next = {CW{1'b0}};
        if (fault_in && resp_in == `BFR_RESP_HICCUP)
          state_next = ST_HICCUP; // [RULE10]
        else if (fault_in && resp_in == `BFR_RESP_LATCH)
          state_next = ST_LATCH; // [RULE11]
      end
      ST_HICCUP: begin
        // Delay counts only while the fault stays away [RULE15]
        if (fault_in)
          cnt_next = {CW{1'b0}};
        else if (cnt_reg == HICCUP_CYCLES[CW-1:0] - 1'b1)
          state_next = ST_RUN; // [RULE10]
        else
          cnt_next = cnt_reg + 1'b1;
      end
      ST_LATCH: begin
        // Only an enable toggle clears; a fault still present under a latch or hiccup code keeps switching off with no gap [RULE16]
        if (rearm_in && fault_in && resp_in == `BFR_RESP_LATCH)
          state_next = ST_LATCH; // [RULE16]
        else if (rearm_in && fault_in && resp_in == `BFR_RESP_HICCUP)
          state_next = ST_HICCUP; // [RULE16]
        else if (rearm_in)
          state_next = ST_RUN; // [RULE11]
      end
      default: state_next = ST_RUN;
    endcase
  end

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_RUN;
      cnt_reg   <= {CW{1'b0}};
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Flag-only codes never reach a stop state [RULE9]
  assign stop_out = (state_reg != ST_RUN);
endmodule

// *** tb/bfr_monitor.sv ***
/*
  Port-level checker for bfr_top, attached by bind.
  Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module bfr_monitor (
  input wire       clock_in,
  input wire       rst_n_in,
  input wire [7:0] reg_addr_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_ack_out,
  input wire       out_ov_in,
  input wire       out_uv_in,
  input wire       in_ov_in,
  input wire       in_uv_in,
  input wire       fault_flag_n_out,
  input wire       pwm_stop_out,
  input wire [3:0] status_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_fault_held;
    (out_ov_in || out_uv_in || in_ov_in || in_uv_in) [*3];
  endsequence
  sequence s_clear_wr;
    reg_wr_in && reg_addr_in == 8'hd7;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_ACK_PULSE: assert property ((reg_rd_in || reg_wr_in) |=> reg_ack_out)
    else $error("ack missing after request");
  AST_ACK_IDLE: assert property (!(reg_rd_in || reg_wr_in) |=> !reg_ack_out)
    else $error("ack without request");
  AST_OUT_OV_STATUS: assert property ($rose(out_ov_in) |-> ##3 status_out[0])
    else $error("output overvoltage status not set");
  AST_IN_UV_STATUS: assert property ($rose(in_uv_in) |-> ##3 status_out[3])
    else $error("input undervoltage status not set");
  AST_FLAG_LOW: assert property (s_fault_held |-> ##1 !fault_flag_n_out)
    else $error("fault flag not low during fault");
  AST_STOP_CAUSE: assert property ($rose(pwm_stop_out) |-> $past(!fault_flag_n_out))
    else $error("switching stopped without a fault");
  AST_STOP_RELEASE: assert property ($fell(pwm_stop_out) |-> fault_flag_n_out && $past(fault_flag_n_out))
    else $error("switching resumed during a fault");
  AST_STATUS_STICKY: assert property (|($past(status_out) & ~status_out) |-> $past(reg_wr_in && reg_addr_in == 8'hd7))
    else $error("status bit dropped without a clear write");
  AST_CLEAR_ACK: assert property (s_clear_wr |=> reg_ack_out)
    else $error("status clear write not acknowledged");
  AST_UNMAPPED_ZERO: assert property (!($past(reg_addr_in) inside {8'hb0, 8'hb6, 8'hb7, 8'hbc, 8'hd7})
      |-> reg_rdata_out == 8'h00)
    else $error("unmapped address read non-zero");
endmodule

bind bfr_top bfr_monitor i_mon (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
  .out_ov_in(out_ov_in), .out_uv_in(out_uv_in), .in_ov_in(in_ov_in), .in_uv_in(in_uv_in),
  .fault_flag_n_out(fault_flag_n_out), .pwm_stop_out(pwm_stop_out), .status_out(status_out));

// *** tb/bfr_host.sv ***
/*
  System controller model: register port master and enable pin driver.
  Assumes bench code calls its tasks hierarchically.
*/
`timescale 1ns/1ps
module bfr_host (
  input  wire       clock_in,
  output reg  [7:0] addr_out  = 8'h00,
  output reg  [7:0] wdata_out = 8'h00,
  output reg        wr_out    = 1'b0,
  output reg        rd_out    = 1'b0,
  output reg        wp_out    = 1'b0,
  output reg        pwm_en_out = 1'b1,
  output reg        master_en_out = 1'b1,
  input  wire [7:0] rdata_in,
  input  wire       ack_in
);
  // One-cycle strobe; protect level is held with the write
  task wr(input logic [7:0] a, input logic [7:0] d, input logic p);
    @(posedge clock_in);
    addr_out <= a; wdata_out <= d; wr_out <= 1'b1; wp_out <= p;
    @(posedge clock_in);
    wr_out <= 1'b0;
    @(posedge clock_in);
    wp_out <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d, output logic k);
    @(posedge clock_in);
    addr_out <= a; rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    // Answer stands for the cycle after the strobe; take it at the next edge
    @(posedge clock_in);
    d = rdata_in;
    k = ack_in;
  endtask
  // Low-then-high toggle on one enable re-arms latched channels
  task toggle_en(input logic sel);
    @(posedge clock_in);
    if (sel) master_en_out <= 1'b0; else pwm_en_out <= 1'b0;
    repeat (4) @(posedge clock_in);
    master_en_out <= 1'b1; pwm_en_out <= 1'b1;
    repeat (6) @(posedge clock_in);
  endtask
endmodule

// *** tb/bus_fault_response_select_bench.sv ***
/*
  Self-checking bench for bfr_top: register access, fault responses, mode pin
  and phase removal. Assumes the hiccup delay is shortened to 20 cycles.
*/
`timescale 1ns/1ps
module bus_fault_response_select_bench;
  localparam HIC = 20;
  logic       clk = 1'b0, rst_n = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [1:0] mode = 2'h0;
  wire  [7:0] addr, wdata, rdata;
  wire        wr, rd, wp, pen, men, ack, flag_n, stop;
  wire  [3:0] status;
  logic [7:0] d;
  logic       k;
  int         err_total = 0, checks_done = 0, cyc = 0;
  always #4 clk = ~clk;
  bfr_host i_host (.clock_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .wp_out(wp),
    .pwm_en_out(pen), .master_en_out(men), .rdata_in(rdata), .ack_in(ack));
  bfr_top #(.HICCUP_CYCLES(HIC)) i_dut (.clock_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .write_protect_in(wp), .reg_rdata_out(rdata),
    .reg_ack_out(ack), .out_ov_in(flt[0]), .out_uv_in(flt[1]), .in_ov_in(flt[2]), .in_uv_in(flt[3]),
    .mode_resp_in(mode), .pwm_en_in(pen), .master_en_in(men), .fault_flag_n_out(flag_n),
    .pwm_stop_out(stop), .status_out(status));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, d, k);
    chk("ack", {7'h0, k}, 8'h01);
    chk("rdata", d, exp);
  endtask
  task wait_chk(input int n, input logic [7:0] e_flag, input logic [7:0] e_stop);
    repeat (n) @(posedge clk);
    #1;
    chk("flag_n", {7'h0, flag_n}, e_flag);
    chk("stop", {7'h0, stop}, e_stop);
  endtask
  // Cycle ceiling well above the roughly 1300 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'hb7, 8'h00);
    rdchk(8'hb6, 8'h00);
    rdchk(8'h55, 8'h00);
    i_host.wr(8'hb7, 8'ha5, 1'b0);
    rdchk(8'hb7, 8'ha5);
    i_host.wr(8'hb7, 8'h5a, 1'b1);
    rdchk(8'hb7, 8'ha5);
    $display("test registers done");
    i_host.wr(8'hb0, 8'h80, 1'b0);
    for (int ch = 0; ch < 4; ch++) begin
      for (int c = 0; c < 4; c++) begin
        i_host.wr(8'hb7, 8'(c << (2 * ch)), 1'b0);
        @(posedge clk) flt[ch] <= 1'b1;
        wait_chk(6, 8'h00, 8'((c == 1) || (c == 2)));
        chk("status", {4'h0, status}, 8'(1 << ch));
        @(posedge clk) flt[ch] <= 1'b0;
        wait_chk(8, 8'h01, 8'((c == 1) || (c == 2)));
        wait_chk(30, 8'h01, 8'(c == 2));
        i_host.toggle_en(c[0]);
        wait_chk(0, 8'h01, 8'h00);
        i_host.wr(8'hd7, 8'h0f, 1'b0);
        rdchk(8'hd7, 8'h00);
      end
    end
    $display("test field codes done");
    i_host.wr(8'hb0, 8'h00, 1'b0);
    @(posedge clk) mode <= 2'h2;
    flt[0] <= 1'b1;
    wait_chk(6, 8'h00, 8'h01);
    i_host.toggle_en(1'b1);
    wait_chk(0, 8'h00, 8'h01);
    @(posedge clk) flt[0] <= 1'b0;
    wait_chk(40, 8'h01, 8'h01);
    i_host.toggle_en(1'b0);
    mode <= 2'h0;
    wait_chk(2, 8'h01, 8'h00);
    $display("test mode pin done");
    @(posedge clk) mode <= 2'h1;
    flt[1] <= 1'b1;
    wait_chk(6, 8'h00, 8'h01);
    @(posedge clk) flt[1] <= 1'b0;
    wait_chk(12, 8'h01, 8'h01);
    @(posedge clk) flt[1] <= 1'b1;
    wait_chk(4, 8'h00, 8'h01);
    @(posedge clk) flt[1] <= 1'b0;
    wait_chk(16, 8'h01, 8'h01);
    wait_chk(12, 8'h01, 8'h00);
    @(posedge clk) mode <= 2'h0;
    $display("test hiccup restart done");
    i_host.wr(8'hb0, 8'h80, 1'b0);
    i_host.wr(8'hbc, 8'h7e, 1'b0);
    wait_chk(6, 8'h01, 8'h00);
    i_host.wr(8'hbc, 8'h0e, 1'b0);
    i_host.wr(8'hb6, 8'h60, 1'b0);
    wait_chk(6, 8'h01, 8'h00);
    i_host.wr(8'hbc, 8'h1e, 1'b0);
    wait_chk(6, 8'h00, 8'h01);
    i_host.wr(8'hbc, 8'h00, 1'b0);
    wait_chk(40, 8'h01, 8'h00);
    $display("test phase removal done");
    end_sim();
  end
endmodule
